// *** design/tpp_top.sv ***
// Function
// - pen arriving sets the on flag and latches raw and dot positions.
// - on event raises the interrupt only when its enable bit is one.
// - writing zero to a set on flag clears it.
// - pen leaving sets the off flag.
// - off event raises the interrupt only when its enable bit is one.
// - writing zero to a set off flag clears it; other writes keep it.
// - one-hot period byte bit n selects 20 ms times n plus one.
// - raw x is twelve bits, upper four bits read zero.
// - raw y is twelve bits, upper four bits read zero.
// - dot x is a sixteen-bit read-only value.
// - dot y is a sixteen-bit read-only value.
// - calibration point a x dot is read-write, resets to zero.
// - calibration point a y dot is read-write, resets to zero.
// - contact declared after three consecutive close samples.
// - sampling runs only while panel enable is one.
// - repeat enable re-raises on events each period during contact.
`timescale 1ns/1ns

module tpp_top #(
  parameter int unsigned UNIT_CYCLES = tpp_pkg::UNIT_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_pen_contact,
  output logic             o_conv_start,
  input  wire logic        i_conv_done,
  input  wire logic [11:0] i_conv_x,
  input  wire logic [11:0] i_conv_y,
  input  wire logic [15:0] i_dot_x,
  input  wire logic [15:0] i_dot_y,
  output logic      [15:0] o_cal_a_x,
  output logic      [15:0] o_cal_a_y,
  output logic             o_irq
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic is_mapped(
    input logic [11:0] addr
  );
    logic [7:0] idx;
    idx = addr[9:2];
    is_mapped = 1'b0;
    if (addr[11:10] == 2'h0 && addr[1:0] == 2'h0) begin
      case (idx)
        tpp_pkg::IDX_CTRL,
        tpp_pkg::IDX_FLAGS,
        tpp_pkg::IDX_PERIOD,
        tpp_pkg::IDX_XRAW,
        tpp_pkg::IDX_YRAW,
        tpp_pkg::IDX_XDOT,
        tpp_pkg::IDX_YDOT,
        tpp_pkg::IDX_CALAX,
        tpp_pkg::IDX_CALAY: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction : is_mapped

  function automatic logic is_close(
    input logic [11:0] a,
    input logic [11:0] b
  );
    logic [11:0] d;
    d = (a > b) ? (a - b) : (b - a);
    is_close = (d <= tpp_pkg::AGREE_TOL);
  endfunction : is_close

  // a flag drops only when it reads one and the host writes zero
  function automatic logic zero_clears(
    input logic cur,
    input logic wbit
  );
    zero_clears = cur & ~wbit;
  endfunction : zero_clears

  // lowest set bit wins, so a stray value still picks a period
  function automatic logic [2:0] period_index(
    input logic [7:0] sel
  );
    period_index = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (sel[i]) begin
        period_index = 3'(i);
      end
    end
  endfunction : period_index

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  localparam logic [tpp_pkg::TICK_W-1:0] TICK_LAST =
    tpp_pkg::TICK_W'(UNIT_CYCLES - 1);

  tpp_pkg::tpp_state_s s_r;
  tpp_pkg::tpp_state_s s_nxt;

  logic [7:0]  idx;
  logic        mapped;
  logic        setup_rd;
  logic        wr;
  logic        sample;
  logic [1:0]  agree_new;
  logic [31:0] rdata;

  assign idx      = i_paddr[9:2];
  assign mapped   = is_mapped(i_paddr);
  assign setup_rd = i_psel & ~i_penable & ~i_pwrite;
  assign wr       = i_psel & i_penable & i_pwrite & mapped;

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    case (idx)
      tpp_pkg::IDX_CTRL: begin
        rdata[3:0] = s_r.ctrl;
      end
      tpp_pkg::IDX_FLAGS: begin
        rdata[tpp_pkg::FLAG_ON]  = s_r.on_f;
        rdata[tpp_pkg::FLAG_OFF] = s_r.off_f;
      end
      tpp_pkg::IDX_PERIOD: begin
        rdata[7:0] = s_r.period;
      end
      tpp_pkg::IDX_XRAW: begin
        rdata[11:0] = s_r.xraw;
      end
      tpp_pkg::IDX_YRAW: begin
        rdata[11:0] = s_r.yraw;
      end
      tpp_pkg::IDX_XDOT: begin
        rdata[15:0] = s_r.xdot;
      end
      tpp_pkg::IDX_YDOT: begin
        rdata[15:0] = s_r.ydot;
      end
      tpp_pkg::IDX_CALAX: begin
        rdata[15:0] = s_r.cal_ax;
      end
      tpp_pkg::IDX_CALAY: begin
        rdata[15:0] = s_r.cal_ay;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    sample = 1'b0;
    agree_new = 2'h0;
    s_nxt.sync1 = i_pen_contact;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.conv_start = 1'b0;

    // unmapped reads return zero even when the index alone decodes
    if (setup_rd) begin
      s_nxt.prdata = mapped ? rdata : 32'h0000_0000;
    end

    // register writes; hardware sets below take priority
    if (wr) begin
      case (idx)
        tpp_pkg::IDX_CTRL: begin
          s_nxt.ctrl = i_pwdata[3:0];
        end
        tpp_pkg::IDX_FLAGS: begin
          if (zero_clears(s_r.on_f, i_pwdata[tpp_pkg::FLAG_ON])) begin
            s_nxt.on_f = 1'b0;
          end
          if (zero_clears(s_r.off_f, i_pwdata[tpp_pkg::FLAG_OFF])) begin
            s_nxt.off_f = 1'b0;
          end
        end
        tpp_pkg::IDX_PERIOD: begin
          s_nxt.period = i_pwdata[7:0];
        end
        tpp_pkg::IDX_CALAX: begin
          s_nxt.cal_ax = i_pwdata[15:0];
        end
        tpp_pkg::IDX_CALAY: begin
          s_nxt.cal_ay = i_pwdata[15:0];
        end
        default: begin
          s_nxt.ctrl = s_nxt.ctrl;
        end
      endcase
    end

    if (!s_r.ctrl[tpp_pkg::CTRL_EN]) begin
      s_nxt.tick    = '0;
      s_nxt.units   = 3'h0;
      s_nxt.st      = tpp_pkg::ST_IDLE;
      s_nxt.agree   = 2'h0;
      s_nxt.contact = 1'b0;
    end else begin
      if (s_r.tick == TICK_LAST) begin
        s_nxt.tick = '0;
        if (s_r.units == period_index(s_r.period)) begin
          s_nxt.units = 3'h0;
          sample = 1'b1;
        end else begin
          s_nxt.units = s_r.units + 3'h1;
        end
      end else begin
        s_nxt.tick = s_r.tick + 1'b1;
      end

      case (s_r.st)
        tpp_pkg::ST_IDLE: begin
          if (sample) begin
            if (s_r.sync2) begin
              s_nxt.conv_start = 1'b1;
              s_nxt.st = tpp_pkg::ST_CONV;
            end else begin
              s_nxt.agree = 2'h0;
              if (s_r.contact) begin
                s_nxt.contact = 1'b0;
                s_nxt.off_f = 1'b1;
              end
            end
          end
        end
        tpp_pkg::ST_CONV: begin
          if (i_conv_done) begin
            s_nxt.st = tpp_pkg::ST_IDLE;
            s_nxt.prev_x = i_conv_x;
            s_nxt.prev_y = i_conv_y;
            if (s_r.agree != 2'h0 &&
                is_close(i_conv_x, s_r.prev_x) &&
                is_close(i_conv_y, s_r.prev_y)) begin
              if (s_r.agree == tpp_pkg::AGREE_NEED) begin
                agree_new = s_r.agree;
              end else begin
                agree_new = s_r.agree + 2'h1;
              end
            end else begin
              agree_new = 2'h1;
            end
            s_nxt.agree = agree_new;
            if (agree_new == tpp_pkg::AGREE_NEED) begin
              if (!s_r.contact || s_r.ctrl[tpp_pkg::CTRL_REP]) begin
                s_nxt.on_f = 1'b1;
                s_nxt.xraw = i_conv_x;
                s_nxt.yraw = i_conv_y;
                s_nxt.xdot = i_dot_x;
                s_nxt.ydot = i_dot_y;
              end
              s_nxt.contact = 1'b1;
            end
          end
        end
        default: begin
          s_nxt.st = tpp_pkg::ST_IDLE;
        end
      endcase
    end

    s_nxt.irq =
      (s_nxt.on_f & s_nxt.ctrl[tpp_pkg::CTRL_ONIE]) |
      (s_nxt.off_f & s_nxt.ctrl[tpp_pkg::CTRL_OFFIE]);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r            <= '0;
      s_r.st         <= tpp_pkg::ST_IDLE;
      s_r.ctrl       <= tpp_pkg::CTRL_RST;
      s_r.period     <= tpp_pkg::PERIOD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_prdata     = s_r.prdata;
  assign o_pready     = 1'b1;
  assign o_pslverr    = i_psel & i_penable & ~mapped;
  assign o_conv_start = s_r.conv_start;
  assign o_cal_a_x    = s_r.cal_ax;
  assign o_cal_a_y    = s_r.cal_ay;
  assign o_irq        = s_r.irq;

endmodule : tpp_top

// *** design/tpp_pkg.sv ***
package tpp_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned UNIT_MS      = 20;
  localparam int unsigned UNIT_CYC     = CLK_HZ / 1000 * UNIT_MS;
  localparam int unsigned TICK_W       = 20;

  // ------------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL      = 8'h20;
  localparam logic [7:0] IDX_FLAGS     = 8'h21;
  localparam logic [7:0] IDX_PERIOD    = 8'h22;
  localparam logic [7:0] IDX_XRAW      = 8'h24;
  localparam logic [7:0] IDX_YRAW      = 8'h26;
  localparam logic [7:0] IDX_XDOT      = 8'h28;
  localparam logic [7:0] IDX_YDOT      = 8'h2a;
  localparam logic [7:0] IDX_CALAX     = 8'h2c;
  localparam logic [7:0] IDX_CALAY     = 8'h2e;

  // ------------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------------
  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_ONIE    = 1;
  localparam int unsigned CTRL_OFFIE   = 2;
  localparam int unsigned CTRL_REP     = 3;
  localparam int unsigned FLAG_ON      = 1;
  localparam int unsigned FLAG_OFF     = 2;
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [7:0]  PERIOD_RST   = 8'h01;
  localparam logic [11:0] AGREE_TOL    = 12'h008;
  localparam logic [1:0]  AGREE_NEED   = 2'h3;

  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } tpp_state_e;

  typedef struct packed {
    tpp_state_e      st;
    logic            sync1;
    logic            sync2;
    logic [TICK_W-1:0] tick;
    logic [2:0]      units;
    logic [3:0]      ctrl;
    logic            on_f;
    logic            off_f;
    logic [7:0]      period;
    logic [11:0]     xraw;
    logic [11:0]     yraw;
    logic [15:0]     xdot;
    logic [15:0]     ydot;
    logic [15:0]     cal_ax;
    logic [15:0]     cal_ay;
    logic [11:0]     prev_x;
    logic [11:0]     prev_y;
    logic [1:0]      agree;
    logic            contact;
    logic            conv_start;
    logic            irq;
    logic [31:0]     prdata;
  } tpp_state_s;

endpackage : tpp_pkg

// *** bench/tpp_properties.sv ***
`timescale 1ns/1ns
module tpp_properties #(
  parameter int unsigned UNIT_CYCLES = 20
) (
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_pen_contact,
  input wire logic        o_conv_start,
  input wire logic        i_conv_done,
  input wire logic [11:0] i_conv_x,
  input wire logic [11:0] i_conv_y,
  input wire logic [15:0] i_dot_x,
  input wire logic [15:0] i_dot_y,
  input wire logic [15:0] o_cal_a_x,
  input wire logic [15:0] o_cal_a_y,
  input wire logic        o_irq
);
  logic       acc, map_a, rd_a, wr_a, en_r;
  logic [7:0] ix;
  assign ix = i_paddr[9:2];
  assign acc = i_psel & i_penable;
  assign map_a = i_paddr[11:10] == 2'h0 && i_paddr[1:0] == 2'h0
    && ix inside {8'h20, 8'h21, 8'h22, 8'h24, 8'h26, 8'h28, 8'h2a,
                  8'h2c, 8'h2e};
  assign rd_a = acc & map_a & ~i_pwrite;
  assign wr_a = acc & map_a & i_pwrite;
  // panel enable as last written by the host
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst)
      en_r <= 1'b0;
    else if (wr_a && ix == tpp_pkg::IDX_CTRL)
      en_r <= i_pwdata[0];
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_start_pulse: assert property (
    o_conv_start |=> !o_conv_start [*8]) else $error("start too close");
  a_idle_quiet: assert property (
    !en_r |=> !o_conv_start) else $error("start while disabled");
  a_cal_write: assert property (
    wr_a && ix == tpp_pkg::IDX_CALAX |=>
      o_cal_a_x == $past(i_pwdata[15:0])) else $error("cal x not written");
  a_cal_read: assert property (
    rd_a && ix == tpp_pkg::IDX_CALAY |-> o_prdata == {16'h0, o_cal_a_y})
    else $error("cal y read wrong");
  a_flag_zero: assert property (
    rd_a && ix == tpp_pkg::IDX_FLAGS |-> (o_prdata & 32'hfffffff9) == 0)
    else $error("unused flag bits set");
  a_raw_width: assert property (
    rd_a && ix inside {8'h24, 8'h26} |-> o_prdata[31:12] == 20'h0)
    else $error("raw upper bits set");
  a_err_map: assert property (
    acc |-> o_pslverr == !map_a && (map_a || i_pwrite || o_prdata == 0))
    else $error("error response wrong");
  a_irq_masked: assert property (
    wr_a && ix == tpp_pkg::IDX_CTRL && i_pwdata[2:1] == 2'h0 |=> !o_irq)
    else $error("irq while masked");
endmodule : tpp_properties

bind tpp_top tpp_properties #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (
  .i_sys_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_pen_contact,
  .o_conv_start, .i_conv_done, .i_conv_x, .i_conv_y, .i_dot_x,
  .i_dot_y, .o_cal_a_x, .o_cal_a_y, .o_irq
);

// *** bench/tpp_panel_model.sv ***
`timescale 1ns/1ns
module tpp_panel_model #(
  parameter logic [11:0] XV = 12'h123,
  parameter logic [11:0] YV = 12'h456
) (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [3:0] i_lat,
  output logic            o_done,
  output logic [11:0]     o_x,
  output logic [11:0]     o_y,
  output logic [15:0]     o_dx,
  output logic [15:0]     o_dy
);
  logic       busy_r = 1'b0;
  logic       done_r = 1'b0;
  logic [3:0] cnt_r = 4'h0;
  // results hold only on the done cycle, inverted otherwise
  always_comb begin
    o_done = done_r;
    o_x = done_r ? XV : ~XV;
    o_y = done_r ? YV : ~YV;
    o_dx = done_r ? {3'h0, XV, 1'b0} : ~{3'h0, XV, 1'b0};
    o_dy = done_r ? {3'h0, YV, 1'b0} : ~{3'h0, YV, 1'b0};
  end
  always @(posedge i_clk) begin
    done_r <= busy_r && cnt_r == 4'h0;
    if (i_start === 1'b1) begin
      busy_r <= 1'b1;
      cnt_r <= i_lat;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : tpp_panel_model

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  localparam int unsigned U = 20;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        touch = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, err, start, done, irq;
  logic [11:0] cx, cy;
  logic [15:0] dx, dy, cax, cay;
  logic [7:0]  rst_ix [9] = '{8'h20, 8'h21, 8'h22, 8'h24, 8'h26, 8'h28,
                              8'h2a, 8'h2c, 8'h2e};
  logic [7:0]  pos_ix [5] = '{8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
  logic [31:0] pos_v [5] = '{32'h2, 32'h123, 32'h456, 32'h246, 32'h8ac};
  int          fail_count = 0;
  int          total_checks = 0;
  int          n_done = 0;
  int          cyc = 0;
  int          base;
  time         t0;

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  tpp_top #(.UNIT_CYCLES(U)) uut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pen_contact(touch), .o_conv_start(start), .i_conv_done(done),
    .i_conv_x(cx), .i_conv_y(cy), .i_dot_x(dx), .i_dot_y(dy),
    .o_cal_a_x(cax), .o_cal_a_y(cay), .o_irq(irq)
  );
  tpp_panel_model panel (
    .i_clk(clk), .i_start(start), .i_lat(lat), .o_done(done),
    .o_x(cx), .o_y(cy), .o_dx(dx), .o_dy(dy)
  );

  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] ix,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic chk_reset();
    foreach (rst_ix[i]) begin
      apb(1'b0, rst_ix[i], 32'h0);
      chk("reset value", q, {31'h0, rst_ix[i] == 8'h22});
    end
    chk("irq after reset", {31'h0, irq}, 32'h0);
  endtask : chk_reset

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk_reset();
    apb(1'b0, 8'h23, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", q, 32'h0);
    apb(1'b1, tpp_pkg::IDX_XRAW, 32'hfff);
    apb(1'b0, tpp_pkg::IDX_XRAW, 32'h0);
    chk("raw x write", q, 32'h0);
    apb(1'b1, tpp_pkg::IDX_CALAX, 32'hffffa5c3);
    apb(1'b1, tpp_pkg::IDX_CALAY, 32'h5a3c);
    apb(1'b0, tpp_pkg::IDX_CALAX, 32'h0);
    chk("cal a x", q, 32'ha5c3);
    chk("cal a y pin", {16'h0, cay}, 32'h5a3c);
    chk("cal a x pin", {16'h0, cax}, 32'ha5c3);
    $display("test registers done");
    touch <= 1'b1;
    base = n_done;
    apb(1'b1, tpp_pkg::IDX_CTRL, 32'h3);
    @(posedge clk iff irq === 1'b1);
    chk("samples to contact", n_done - base, 32'h3);
    foreach (pos_ix[i]) begin
      apb(1'b0, pos_ix[i], 32'h0);
      chk("position", q, pos_v[i]);
    end
    apb(1'b1, tpp_pkg::IDX_FLAGS, 32'h2);
    chk("on irq", {31'h0, irq}, 32'h1);
    apb(1'b1, tpp_pkg::IDX_FLAGS, 32'h0);
    chk("on irq clear", {31'h0, irq}, 32'h0);
    apb(1'b1, tpp_pkg::IDX_CTRL, 32'h9);
    repeat (3 * U) @(posedge clk);
    apb(1'b0, tpp_pkg::IDX_FLAGS, 32'h0);
    chk("repeat flag", q, 32'h2);
    chk("masked irq", {31'h0, irq}, 32'h0);
    $display("test contact done");
    apb(1'b1, tpp_pkg::IDX_CTRL, 32'h5);
    apb(1'b1, tpp_pkg::IDX_FLAGS, 32'h0);
    touch <= 1'b0;
    @(posedge clk iff irq === 1'b1);
    apb(1'b1, tpp_pkg::IDX_FLAGS, 32'hfd);
    apb(1'b0, tpp_pkg::IDX_FLAGS, 32'h0);
    chk("off flag", q, 32'h4);
    chk("off irq", {31'h0, irq}, 32'h1);
    apb(1'b1, tpp_pkg::IDX_FLAGS, 32'h0);
    chk("off irq clear", {31'h0, irq}, 32'h0);
    $display("test release done");
    touch <= 1'b1;
    lat <= 4'h4;
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, tpp_pkg::IDX_PERIOD, 32'h1 << n);
      apb(1'b0, tpp_pkg::IDX_PERIOD, 32'h0);
      chk("period", q, 32'h1 << n);
      @(posedge clk iff start === 1'b1);
      t0 = $time;
      @(posedge clk iff start === 1'b1);
      base = ($time - t0) / 40 - U * (n + 1);
      chk("gap", base, 32'h0);
    end
    apb(1'b1, tpp_pkg::IDX_CTRL, 32'h0);
    repeat (2 * U) @(posedge clk);
    $display("test sampling done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk_reset();
    $display("test reset done");
    end_sim();
  end
endmodule : testbench
